// file: dcf_consts.svh
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// register byte offsets
`define DCF_OFS_EMPTY_OFFSET 8'h00
`define DCF_OFS_FULL_OFFSET  8'h04
`define DCF_OFS_STATUS       8'h08
`define DCF_OFS_LEVEL        8'h0c
`define DCF_OFS_IRQ_STATUS   8'h10
`define DCF_OFS_IRQ_CLEAR    8'h14
`define DCF_OFS_IRQ_ENABLE   8'h18

// reset values
`define DCF_RST_OFFSET       32'h0000_007f
`define DCF_RST_IRQ_ENABLE   4'h0

// field positions in the status word
`define DCF_ST_MODE_BIT      7

`endif

// file: dcf_far_side.sv
`timescale 1ns/1ps
// writer and reader on the far side of the fifo; their clock edges are tick pulses on pclk
module dcf_far_side #(
    parameter int DW = 18
) (
    // clock
    input  wire logic      pclk,
    // write side
    output logic           wr_tick,
    output logic           write_enable_n,
    output logic [DW-1:0]  data_in,
    // read side
    output logic           rd_tick,
    output logic           read_enable_n
);
    // idle levels from time zero
    initial begin
        wr_tick        = 1'b0;
        write_enable_n = 1'b1;
        data_in        = '0;
        rd_tick        = 1'b0;
        read_enable_n  = 1'b1;
    end

    // one write edge; then one spare cycle so the flags it caused are visible
    task automatic wr(input logic en_n, input logic [DW-1:0] d);
        wr_tick        <= 1'b1;
        write_enable_n <= en_n;
        data_in        <= d;
        @(posedge pclk);
        wr_tick        <= 1'b0;
        write_enable_n <= 1'b1;
        data_in        <= ~d; // released lines never hold the old word
        @(posedge pclk);
    endtask

    // one read edge; enable low asks for the next word
    task automatic rd(input logic en_n);
        rd_tick       <= 1'b1;
        read_enable_n <= en_n;
        @(posedge pclk);
        rd_tick       <= 1'b0;
        read_enable_n <= 1'b1;
        @(posedge pclk);
    endtask
endmodule

// file: dcf_pkg.sv
package dcf_pkg;

    // timing mode caught during master reset
    typedef enum logic {
        DCF_STANDARD,
        DCF_FALL_THROUGH
    } dcf_mode_type;

    // all status pins, active low
    typedef struct packed {
        logic output_ready_n;
        logic empty_flag_n;
        logic input_space_n;
        logic full_flag_n;
        logic almost_empty_n;
        logic half_full_n;
        logic almost_full_n;
    } dcf_flags_type;

    // interrupt events, one bit each
    typedef struct packed {
        logic almost_full;
        logic half_full;
        logic underflow;
        logic overflow;
    } dcf_irq_type;

endpackage

// file: dcf_timing_fifo.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dcf_consts.svh"

module dcf_timing_fifo #(
    parameter int DEPTH       = 8192,
    parameter bit NARROW      = 1'b0,
    parameter int WIDE_BITS   = 18,
    parameter int NARROW_BITS = 9
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // fifo control
    input  wire logic                     master_reset_n,
    input  wire logic                     mode_select_serial_in,
    // write side
    input  wire logic                     wr_tick,
    input  wire logic                     write_enable_n,
    input  wire logic [(NARROW ? NARROW_BITS : WIDE_BITS)-1:0] data_in,
    // read side
    input  wire logic                     rd_tick,
    input  wire logic                     read_enable_n,
    output logic [(NARROW ? NARROW_BITS : WIDE_BITS)-1:0]      data_out,
    output dcf_pkg::dcf_flags_type        flags,
    // apb slave
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // interrupt
    output logic                          irq
);
    import dcf_pkg::*;

    localparam int DW        = NARROW ? NARROW_BITS : WIDE_BITS;
    localparam int MEM_WORDS = NARROW ? 2 * DEPTH : DEPTH;
    localparam int AW        = $clog2(MEM_WORDS);
    localparam int PW        = AW + 1;
    localparam logic [PW-1:0] MEM_FULL = PW'(MEM_WORDS);
    localparam logic [PW-1:0] CAP_FT   = PW'(MEM_WORDS + 1);
    localparam logic [PW-1:0] HF_STD   = PW'(MEM_WORDS / 2 + 1);
    localparam logic [PW-1:0] HF_FT    = PW'(MEM_WORDS / 2 + 2);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    dcf_mode_type   mode_q, mode_d;
    logic [DW-1:0]  mem [MEM_WORDS];
    logic [PW-1:0]  wptr_q, wptr_d, ws_rptr_q, ws_rptr_d, ws_rel_q, ws_rel_d;
    logic           full_q, full_d, paf_q, paf_d, wr_ok;
    logic [PW-1:0]  rptr_q, rptr_d, rel_q, rel_d, rs1_q, rs1_d, rs2_q, rs2_d;
    logic           valid_q, valid_d, ef_q, ef_d, pae_q, pae_d, rd_fail;
    logic [DW-1:0]  dout_q, dout_d;
    logic [PW-1:0]  level_d, level_r, hf_thr, empty_ofs_q, empty_ofs_d, full_ofs_q, full_ofs_d;
    logic           hf_q, hf_d;
    dcf_flags_type  flags_q, flags_d;
    logic [31:0]    prdata_q, prdata_d;
    logic           pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d, done;
    dcf_irq_type    irq_st_q, irq_st_d, irq_en_q, irq_en_d, ev, clr;

    // mode latch, open only while master reset is low
    always_comb begin
        mode_d = mode_q;
        if (!master_reset_n) begin
            mode_d = dcf_mode_type'(mode_select_serial_in);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= DCF_STANDARD;
        end else begin
            mode_q <= mode_d;
        end
    end

    // storage array, written at the write pointer
    always_ff @(posedge pclk) begin
        if (wr_ok) begin
            mem[wptr_q[AW-1:0]] <= data_in;
        end
    end

    // write side: pointer, staged read pointers, space and almost-full
    assign wr_ok = wr_tick && !write_enable_n && !full_q && master_reset_n;

    always_comb begin
        wptr_d    = wptr_q + PW'(wr_ok);
        ws_rptr_d = ws_rptr_q;
        ws_rel_d  = ws_rel_q;
        full_d    = full_q;
        paf_d     = paf_q;
        if (wr_tick) begin
            ws_rptr_d = bin2gray(rptr_q);
            ws_rel_d  = bin2gray(rel_q);
            // memory full; in fall-through the output word adds one more
            full_d    = (wptr_d - gray2bin(ws_rptr_q)) == MEM_FULL;
            paf_d     = (wptr_d - gray2bin(ws_rel_q)) <
                        ((mode_q == DCF_FALL_THROUGH ? CAP_FT : MEM_FULL) - full_ofs_q);
        end
        if (!master_reset_n) begin
            wptr_d    = '0;
            ws_rptr_d = '0;
            ws_rel_d  = '0;
            full_d    = 1'b0;
            paf_d     = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q    <= '0;
            ws_rptr_q <= '0;
            ws_rel_q  <= '0;
            full_q    <= 1'b0;
            paf_q     <= 1'b1;
        end else begin
            wptr_q    <= wptr_d;
            ws_rptr_q <= ws_rptr_d;
            ws_rel_q  <= ws_rel_d;
            full_q    <= full_d;
            paf_q     <= paf_d;
        end
    end

    // read side: two staged write pointers, output word, empty and almost-empty
    always_comb begin
        rptr_d  = rptr_q;
        rel_d   = rel_q;
        valid_d = valid_q;
        dout_d  = dout_q;
        ef_d    = ef_q;
        pae_d   = pae_q;
        rs1_d   = rs1_q;
        rs2_d   = rs2_q;
        rd_fail = 1'b0;
        level_r = '0;
        if (rd_tick && master_reset_n) begin
            rs1_d = bin2gray(wptr_q);
            rs2_d = rs1_q;
            if (mode_q == DCF_FALL_THROUGH) begin
                if (!read_enable_n && valid_q) begin
                    rel_d   = rel_q + 1'b1;
                    valid_d = 1'b0;
                end else if (!read_enable_n) begin
                    rd_fail = 1'b1;
                end
                // third tick after a write shifts the word out unrequested
                if (!valid_d && gray2bin(rs2_q) != rptr_q) begin
                    dout_d  = mem[rptr_q[AW-1:0]];
                    rptr_d  = rptr_q + 1'b1;
                    valid_d = 1'b1;
                end
                level_r = gray2bin(rs1_q) - rel_d;
                pae_d   = level_r > (empty_ofs_q + 1'b1);
            end else begin
                if (!read_enable_n && ef_q) begin
                    dout_d = mem[rptr_q[AW-1:0]];
                    rptr_d = rptr_q + 1'b1;
                end else if (!read_enable_n) begin
                    rd_fail = 1'b1;
                end
                rel_d   = rptr_d;
                ef_d    = gray2bin(rs1_q) != rptr_d;
                level_r = gray2bin(rs1_q) - rel_d;
                pae_d   = level_r > empty_ofs_q;
            end
        end
        if (!master_reset_n) begin
            rptr_d  = '0;
            rel_d   = '0;
            valid_d = 1'b0;
            ef_d    = 1'b0;
            pae_d   = 1'b0;
            rs1_d   = '0;
            rs2_d   = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_q  <= '0;
            rel_q   <= '0;
            valid_q <= 1'b0;
            dout_q  <= '0;
            ef_q    <= 1'b0;
            pae_q   <= 1'b0;
            rs1_q   <= '0;
            rs2_q   <= '0;
        end else begin
            rptr_q  <= rptr_d;
            rel_q   <= rel_d;
            valid_q <= valid_d;
            dout_q  <= dout_d;
            ef_q    <= ef_d;
            pae_q   <= pae_d;
            rs1_q   <= rs1_d;
            rs2_q   <= rs2_d;
        end
    end

    // half-full follows the live level, moved by both sides
    assign level_d = wptr_d - rel_d;
    assign hf_thr  = (mode_q == DCF_FALL_THROUGH) ? HF_FT : HF_STD;

    // pin image; the pair unused by the current mode rests high
    always_comb begin
        hf_d                   = !master_reset_n || (level_d < hf_thr);
        flags_d.output_ready_n = (mode_d == DCF_FALL_THROUGH) ? !valid_d : 1'b1;
        flags_d.input_space_n  = (mode_d == DCF_FALL_THROUGH) ? full_d : 1'b1;
        flags_d.empty_flag_n   = (mode_d == DCF_FALL_THROUGH) ? 1'b1 : ef_d;
        flags_d.full_flag_n    = (mode_d == DCF_FALL_THROUGH) ? 1'b1 : !full_d;
        flags_d.almost_empty_n = pae_d;
        flags_d.half_full_n    = hf_d;
        flags_d.almost_full_n  = paf_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_q    <= 1'b1;
            flags_q <= '1;
        end else begin
            hf_q    <= hf_d;
            flags_q <= flags_d;
        end
    end

    // apb slave: one wait state, data and error registered with ready
    assign done = psel && penable && pready_q;
    assign clr  = (done && pwrite && paddr == `DCF_OFS_IRQ_CLEAR) ? pwdata[3:0] : '0;
    assign ev   = '{almost_full: paf_q && !paf_d, half_full: hf_q && !hf_d,
                    underflow: rd_fail, overflow: wr_tick && !write_enable_n && full_q};

    always_comb begin
        pready_d    = psel && penable && !pready_q;
        prdata_d    = prdata_q;
        pslverr_d   = 1'b0;
        empty_ofs_d = empty_ofs_q;
        full_ofs_d  = full_ofs_q;
        irq_en_d    = irq_en_q;
        if (pready_d) begin
            prdata_d = '0;
            unique case (paddr)
                `DCF_OFS_EMPTY_OFFSET: prdata_d = 32'(empty_ofs_q);
                `DCF_OFS_FULL_OFFSET:  prdata_d = 32'(full_ofs_q);
                `DCF_OFS_STATUS:       prdata_d = {24'h00_0000, mode_q == DCF_FALL_THROUGH,
                                                   flags_q};
                `DCF_OFS_LEVEL:        prdata_d = 32'(wptr_q - rel_q);
                `DCF_OFS_IRQ_STATUS:   prdata_d = {28'h000_0000, irq_st_q};
                `DCF_OFS_IRQ_CLEAR:    prdata_d = '0; // write-only
                `DCF_OFS_IRQ_ENABLE:   prdata_d = {28'h000_0000, irq_en_q};
                default:               pslverr_d = 1'b1;
            endcase
        end
        if (done && pwrite) begin
            unique case (paddr)
                `DCF_OFS_EMPTY_OFFSET: empty_ofs_d = pwdata[PW-1:0];
                `DCF_OFS_FULL_OFFSET:  full_ofs_d  = pwdata[PW-1:0];
                `DCF_OFS_IRQ_ENABLE:   irq_en_d    = pwdata[3:0];
                default:               irq_en_d    = irq_en_q;
            endcase
        end
        // a new event wins over a clear in the same cycle
        irq_st_d = (irq_st_q & ~clr) | ev;
        irq_d    = |(irq_st_d & irq_en_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q    <= 1'b0;
            prdata_q    <= '0;
            pslverr_q   <= 1'b0;
            empty_ofs_q <= PW'(`DCF_RST_OFFSET);
            full_ofs_q  <= PW'(`DCF_RST_OFFSET);
            irq_en_q    <= `DCF_RST_IRQ_ENABLE;
            irq_st_q    <= '0;
            irq_q       <= 1'b0;
        end else begin
            pready_q    <= pready_d;
            prdata_q    <= prdata_d;
            pslverr_q   <= pslverr_d;
            empty_ofs_q <= empty_ofs_d;
            full_ofs_q  <= full_ofs_d;
            irq_en_q    <= irq_en_d;
            irq_st_q    <= irq_st_d;
            irq_q       <= irq_d;
        end
    end

    // outputs straight from flops
    assign data_out = dout_q;
    assign flags    = flags_q;
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign irq      = irq_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_latch: assert property (
        !master_reset_n |=> mode_q == dcf_mode_type'($past(mode_select_serial_in)))
        else $error("mode not caught during master reset");
    a_mode_hold: assert property (
        master_reset_n |=> mode_q == $past(mode_q))
        else $error("mode changed outside master reset");
    a_write_store: assert property (
        wr_ok |=> wptr_q == $past(wptr_q) + 1'b1 &&
                  mem[$past(wptr_q[AW-1:0])] == $past(data_in))
        else $error("accepted write not stored");
    a_mem_bound: assert property (
        (wptr_q - rptr_q) <= MEM_FULL)
        else $error("memory overfilled");
    a_level_cap: assert property (
        (wptr_q - rel_q) <= ((mode_q == DCF_FALL_THROUGH) ? CAP_FT : MEM_FULL))
        else $error("stored words exceed capacity");
    a_empty_ignored: assert property (
        rd_tick && !read_enable_n && master_reset_n && mode_q == DCF_STANDARD && !ef_q
        |=> rptr_q == $past(rptr_q))
        else $error("read pointer moved while empty");
    a_or_release: assert property (
        $rose(flags_q.output_ready_n) && $past(master_reset_n)
        |-> $past(rd_tick) && !$past(read_enable_n) && data_out == $past(data_out))
        else $error("output-ready rose without a read");
    a_first_fall: assert property (
        mode_q == DCF_FALL_THROUGH && master_reset_n && rd_tick && !valid_q &&
        gray2bin(rs2_q) != rptr_q
        |=> !flags_q.output_ready_n && data_out == $past(mem[rptr_q[AW-1:0]]))
        else $error("fall-through word not presented");
    a_half_flag: assert property (
        master_reset_n |=> flags_q.half_full_n == ($past(level_d) < $past(hf_thr)))
        else $error("half-full flag wrong");
    a_almost_full: assert property (
        wr_ok && mode_q == DCF_FALL_THROUGH &&
        (wptr_d - gray2bin(ws_rel_q)) >= (CAP_FT - full_ofs_q)
        |=> !flags_q.almost_full_n)
        else $error("almost-full not asserted");
    a_almost_empty: assert property (
        rd_tick && master_reset_n && mode_q == DCF_FALL_THROUGH &&
        (gray2bin(rs1_q) - rel_d) > (empty_ofs_q + 1'b1)
        |=> flags_q.almost_empty_n)
        else $error("almost-empty not released");

    c_fall_through: cover property (mode_q == DCF_FALL_THROUGH ##1 $fell(flags_q.output_ready_n));
    c_std_full: cover property (mode_q == DCF_STANDARD && $fell(flags_q.full_flag_n));
    c_irq: cover property ($rose(irq));

endmodule

// file: dcf_timing_fifo_tb_top.sv
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_timing_fifo_tb_top;
    import dcf_pkg::*;
    localparam int DW = 18;
    localparam int D  = 17; // fall-through capacity of a 16-word memory
    localparam int NE = 3;  // empty offset used in the run
    localparam int MF = 4;  // full offset used in the run
    localparam int OW = $clog2(D - 1) + 1; // offset registers are pointer wide

    // clock, resets and apb master
    logic                pclk                  = 1'b0;
    logic                presetn;
    logic                master_reset_n;
    logic                mode_select_serial_in;
    logic [7:0]          paddr;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [31:0]         pwdata;
    // far side and observed outputs
    logic                wr_tick;
    logic                write_enable_n;
    logic                rd_tick;
    logic                read_enable_n;
    logic [DW-1:0]       data_in;
    logic [DW-1:0]       data_out;
    dcf_flags_type       flags;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    // bench bookkeeping
    int                  fail_count  = 0;
    int                  checks_done = 0;
    logic [31:0]         rdv;
    logic                err;
    logic [DW-1:0]       w;
    logic [DW-1:0]       q[$];

    always #2.5 pclk = ~pclk;

    dcf_timing_fifo #(.DEPTH(16)) dcf_timing_fifo_inst (
        .pclk(pclk), .presetn(presetn), .master_reset_n(master_reset_n),
        .mode_select_serial_in(mode_select_serial_in), .wr_tick(wr_tick),
        .write_enable_n(write_enable_n), .data_in(data_in), .rd_tick(rd_tick),
        .read_enable_n(read_enable_n), .data_out(data_out), .flags(flags),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    dcf_far_side #(.DW(DW)) dcf_far_side_inst (
        .pclk(pclk), .wr_tick(wr_tick), .write_enable_n(write_enable_n),
        .data_in(data_in), .rd_tick(rd_tick), .read_enable_n(read_enable_n));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge; one idle edge follows it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait for ready; only the watchdog ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // fifo reset; the mode pin flips right after release to prove the latch holds
    task automatic mreset(input logic m);
        master_reset_n        <= 1'b0;
        mode_select_serial_in <= m;
        repeat (2) @(posedge pclk);
        master_reset_n        <= 1'b1;
        mode_select_serial_in <= ~m;
        @(posedge pclk);
    endtask

    function automatic logic [DW-1:0] word(input int i);
        return DW'(32'h2c5a1 ^ (i * 32'h0b3));
    endfunction

    // counts and verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // test sequence
    initial begin
        // idle levels from time zero, reset asserted
        presetn               = 1'b0;
        master_reset_n        = 1'b1;
        mode_select_serial_in = 1'b0;
        paddr                 = 8'h00;
        psel                  = 1'b0;
        penable               = 1'b0;
        pwrite                = 1'b0;
        pwdata                = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `DCF_OFS_FULL_OFFSET, 32'h0, rdv, err);
        chk(rdv, `DCF_RST_OFFSET & ((32'h1 << OW) - 32'h1));
        apb(1'b0, `DCF_OFS_IRQ_ENABLE, 32'h0, rdv, err);
        chk(rdv, 32'(`DCF_RST_IRQ_ENABLE));
        apb(1'b0, 8'h40, 32'h0, rdv, err);
        chk({err, rdv[30:0]}, 32'h8000_0000);
        $display("test registers done");
        // fall-through: mode, flags, first word latency
        mreset(1'b1);
        apb(1'b1, `DCF_OFS_EMPTY_OFFSET, 32'(NE), rdv, err);
        apb(1'b1, `DCF_OFS_FULL_OFFSET, 32'(MF), rdv, err);
        apb(1'b0, `DCF_OFS_STATUS, 32'h0, rdv, err);
        chk(32'(rdv[`DCF_ST_MODE_BIT]), 32'h1);
        chk(32'(flags[6:3]), 32'hd);
        w = word(1);
        dcf_far_side_inst.wr(1'b0, w);
        repeat (2) dcf_far_side_inst.rd(1'b1);
        chk(32'(flags.output_ready_n), 32'h1);
        dcf_far_side_inst.rd(1'b1);
        chk(32'(data_out), 32'(w));
        chk(32'(flags.output_ready_n), 32'h0);
        // fill to capacity with no reads
        for (int k = 2; k <= D; k++) begin
            w = word(k);
            q.push_back(w);
            dcf_far_side_inst.wr(1'b0, w);
            repeat (3) dcf_far_side_inst.rd(1'b1);
            chk(32'(flags.half_full_n), 32'(k < (D - 1) / 2 + 2));
            chk(32'(flags.almost_full_n), 32'(k < D - MF));
            chk(32'(flags.almost_empty_n), 32'(k >= NE + 2));
            chk(32'(flags.input_space_n), 32'(k >= D));
        end
        apb(1'b0, `DCF_OFS_LEVEL, 32'h0, rdv, err);
        chk(rdv, 32'(D));
        $display("test fall-through fill done");
        // write while full: masked, then enabled, then cleared
        dcf_far_side_inst.wr(1'b0, word(99));
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b0, `DCF_OFS_IRQ_STATUS, 32'h0, rdv, err);
        chk(32'(rdv[0]), 32'h1);
        apb(1'b1, `DCF_OFS_IRQ_ENABLE, 32'h3, rdv, err);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, `DCF_OFS_IRQ_CLEAR, 32'h1, rdv, err);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        // first read from full, then two write edges restore space
        chk(32'(data_out), 32'(word(1)));
        dcf_far_side_inst.rd(1'b0);
        dcf_far_side_inst.wr(1'b1, '0);
        chk(32'(flags.input_space_n), 32'h1);
        dcf_far_side_inst.wr(1'b1, '0);
        chk(32'(flags.input_space_n), 32'h0);
        // drain in order
        while (q.size() > 0) begin
            chk(32'(data_out), 32'(q.pop_front()));
            chk(32'(flags.output_ready_n), 32'h0);
            dcf_far_side_inst.rd(1'b0);
        end
        chk(32'(flags.output_ready_n), 32'h1);
        chk(32'(data_out), 32'(word(D)));
        dcf_far_side_inst.rd(1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(data_out), 32'(word(D)));
        chk(32'(irq), 32'h1);
        apb(1'b1, `DCF_OFS_IRQ_CLEAR, 32'h3, rdv, err);
        $display("test fall-through drain done");
        // standard mode
        mreset(1'b0);
        apb(1'b0, `DCF_OFS_STATUS, 32'h0, rdv, err);
        chk(32'(rdv[`DCF_ST_MODE_BIT]), 32'h0);
        chk(32'(flags[6:3]), 32'hb);
        w = word(200);
        dcf_far_side_inst.wr(1'b0, w);
        dcf_far_side_inst.rd(1'b1);
        chk(32'(flags.empty_flag_n), 32'h0);
        dcf_far_side_inst.rd(1'b1);
        chk(32'(flags.empty_flag_n), 32'h1);
        chk(32'(data_out), 32'(word(D)));
        dcf_far_side_inst.rd(1'b0);
        chk(32'(data_out), 32'(w));
        chk(32'(flags.empty_flag_n), 32'h0);
        for (int k = 1; k <= D - 1; k++) begin
            dcf_far_side_inst.wr(1'b0, word(300 + k));
            chk(32'(flags.full_flag_n), 32'(k < D - 1));
        end
        $display("test standard mode done");
        conclude();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
endmodule
